// file: shared/astx_consts.svh
// Purpose: Register map, field positions and timing constants of the serial core
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: Included by the design file by its bare name
`ifndef ASTX_CONSTS_SVH
`define ASTX_CONSTS_SVH
// Register byte offsets
`define ASTX_OFS_STATUS 8'h00
`define ASTX_OFS_DATA 8'h04
`define ASTX_OFS_CTRL1 8'h08
`define ASTX_OFS_CTRL2 8'h0C
`define ASTX_OFS_BAUD 8'h10
`define ASTX_OFS_ETX 8'h14
`define ASTX_OFS_ERX 8'h18
// Control 1 fields
`define ASTX_C1_WORD9 0
`define ASTX_C1_TX9 1
`define ASTX_C1_RX9 2
// Control 2 fields
`define ASTX_C2_TXEN 0
`define ASTX_C2_RXEN 1
`define ASTX_C2_BRK 2
`define ASTX_C2_TIE 3
`define ASTX_C2_TX_COMPLETE_IRQ_ENABLE 4
`define ASTX_C2_RIE 5
`define ASTX_C2_IDLE_LINE_IRQ_ENABLE 6
// Baud select fields
`define ASTX_BR_PR 1:0
`define ASTX_BR_TR 4:2
`define ASTX_BR_RR 7:5
// Common prescaler factors
`define ASTX_PR_SEL0 5'h01
`define ASTX_PR_SEL1 5'h03
`define ASTX_PR_SEL2 5'h04
`define ASTX_PR_SEL3 5'h0D
// Oversampling positions, sample n sits at index n-1
`define ASTX_SUB_LAST 4'hF
`define ASTX_SUB_S3 4'h2
`define ASTX_SUB_S5 4'h4
`define ASTX_SUB_S7 4'h6
`define ASTX_SUB_S8 4'h7
`define ASTX_SUB_S10 4'h9
// Frame lengths with start and stop, data bit counts, and full-frame fill patterns
`define ASTX_BITS_8 4'hA
`define ASTX_BITS_9 4'hB
`define ASTX_DATA_8 4'h8
`define ASTX_DATA_9 4'h9
`define ASTX_FRAME_ONES 11'h7FF
`define ASTX_FRAME_ZERO 11'h000
// Reset values
`define ASTX_RST_BYTE 8'h00
`define ASTX_RST_WORD 9'h000
`endif

// file: shared/astx_pkg.sv
// Purpose: Types shared by the serial core and its bench
// Assumes: APB signal names as published
// Notes: Status bits in the order they appear in the status word
package astx_pkg;
    typedef enum logic [1:0] {RX_HUNT, RX_START, RX_DATA} astx_rx_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } astx_apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } astx_apb_rsp_s;
    typedef struct packed {
        logic fe;
        logic nf;
        logic ovr;
        logic idle;
        logic rxf;
        logic tc;
        logic tx_buffer_empty_flag;
    } astx_status_s;
endpackage

// file: verilog/astx_uart.sv
// Purpose: Full-duplex asynchronous serial core with APB registers
// Assumes: serial_in_pin synchronous to clk; global_irq_mask high blocks irq_req
// Notes: x16 oversampling, independent tx and rx rate generators
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "astx_consts.svh"
`default_nettype none
module astx_uart (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire astx_pkg::astx_apb_req_s apb_req,
    output var astx_pkg::astx_apb_rsp_s apb_rsp,
    // Serial pins
    input wire logic serial_in_pin,
    output logic tx_out,
    output logic tx_oe,
    // Interrupt request
    input wire logic global_irq_mask,
    output logic irq_req
);
    import astx_pkg::*;

    // ********************************
    // Functions
    // ********************************
    function automatic logic [4:0] pr_val(input logic [1:0] s);
        unique case (s)
            2'h0: pr_val = `ASTX_PR_SEL0;
            2'h1: pr_val = `ASTX_PR_SEL1;
            2'h2: pr_val = `ASTX_PR_SEL2;
            2'h3: pr_val = `ASTX_PR_SEL3;
        endcase
    endfunction

    // Start low, data LSB first, stop high
    function automatic logic [10:0] tx_frame(input logic w9, input logic [8:0] d);
        tx_frame = w9 ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    endfunction

    // ********************************
    // APB decode
    // ********************************
    logic [31:0] prdata_q;
    logic pend_q;
    logic word9_q, tx_ninth_q, tx_en_q, rx_en_q, brk_q;
    logic tie_q, tx_complete_irq_enable_q, rie_q, idle_line_irq_enable_q;
    logic [7:0] baud_q, etx_q, erx_q;
    logic tx_buffer_empty_flag_q, tc_q, rx_full_q, idle_q, ovr_q, nf_q, fe_q;
    logic [8:0] rbuf_q;
    astx_status_s status;

    // Access strobes and register selects
    wire acc = apb_req.psel & apb_req.penable;
    wire wr = acc & apb_req.pwrite;
    wire rd = acc & ~apb_req.pwrite;
    wire sel_st = apb_req.paddr == `ASTX_OFS_STATUS;
    wire sel_dat = apb_req.paddr == `ASTX_OFS_DATA;
    wire sel_c1 = apb_req.paddr == `ASTX_OFS_CTRL1;
    wire sel_c2 = apb_req.paddr == `ASTX_OFS_CTRL2;
    wire sel_br = apb_req.paddr == `ASTX_OFS_BAUD;
    wire sel_etx = apb_req.paddr == `ASTX_OFS_ETX;
    wire sel_erx = apb_req.paddr == `ASTX_OFS_ERX;
    wire mapped = sel_st | sel_dat | sel_c1 | sel_c2 | sel_br | sel_etx | sel_erx;
    wire data_wr = wr & sel_dat;
    wire wr_clr = data_wr & pend_q;
    wire rd_clr = rd & sel_dat & pend_q;
    wire [31:0] pw = apb_req.pwdata;

    assign status = '{fe: fe_q, nf: nf_q, ovr: ovr_q, idle: idle_q, rxf: rx_full_q,
                      tc: tc_q, tx_buffer_empty_flag: tx_buffer_empty_flag_q};

    // Read mux, sampled in the setup cycle so prdata is a flop
    wire [31:0] rmux = sel_st ? 32'(status) :
                       sel_dat ? 32'(rbuf_q[7:0]) :
                       sel_c1 ? 32'({rbuf_q[8], tx_ninth_q, word9_q}) :
                       sel_c2 ? 32'({idle_line_irq_enable_q, rie_q, tx_complete_irq_enable_q, tie_q, brk_q, rx_en_q, tx_en_q}) :
                       sel_br ? 32'(baud_q) :
                       sel_etx ? 32'(etx_q) :
                       sel_erx ? 32'(erx_q) : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_req.psel & ~apb_req.penable) begin
            prdata_q <= rmux;
        end
    end

    // Zero wait states; unmapped addresses answer with an error
    assign apb_rsp = '{pready: 1'b1, pslverr: acc & ~mapped, prdata: prdata_q};

    // Clear arming: a status access arms, any data access consumes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= (acc & sel_st) | (pend_q & ~(acc & sel_dat));
        end
    end

    // Control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {word9_q, tx_ninth_q} <= 2'b00;
            {tx_en_q, rx_en_q, brk_q, tie_q, tx_complete_irq_enable_q, rie_q, idle_line_irq_enable_q} <= 7'h00;
        end else begin
            if (wr & sel_c1) begin
                word9_q <= pw[`ASTX_C1_WORD9];
                tx_ninth_q <= pw[`ASTX_C1_TX9];
            end
            if (wr & sel_c2) begin
                tx_en_q <= pw[`ASTX_C2_TXEN];
                rx_en_q <= pw[`ASTX_C2_RXEN];
                brk_q <= pw[`ASTX_C2_BRK];
                tie_q <= pw[`ASTX_C2_TIE];
                tx_complete_irq_enable_q <= pw[`ASTX_C2_TX_COMPLETE_IRQ_ENABLE];
                rie_q <= pw[`ASTX_C2_RIE];
                idle_line_irq_enable_q <= pw[`ASTX_C2_IDLE_LINE_IRQ_ENABLE];
            end
        end
    end

    // Baud registers; changing them mid-frame only retimes the bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            baud_q <= `ASTX_RST_BYTE;
            etx_q <= `ASTX_RST_BYTE;
            erx_q <= `ASTX_RST_BYTE;
        end else begin
            if (wr & sel_br) baud_q <= pw[7:0];
            if (wr & sel_etx) etx_q <= pw[7:0];
            if (wr & sel_erx) erx_q <= pw[7:0];
        end
    end

    // ********************************
    // Rate generators, index 0 transmit, 1 receive
    // ********************************
    logic [1:0] tick;
    for (genvar g = 0; g < 2; g++) begin : g_baud
        logic [18:0] cnt_q;
        wire [2:0] rsel = (g == 0) ? baud_q[`ASTX_BR_TR] : baud_q[`ASTX_BR_RR];
        wire [7:0] ext = (g == 0) ? etx_q : erx_q;
        wire [7:0] ext_f = (ext == 8'h00) ? 8'h01 : ext;
        // One tick per oversample; the x16 is counted by the bit timers
        wire [18:0] div = 19'(pr_val(baud_q[`ASTX_BR_PR])) * (19'h0_0001 << rsel)
                          * 19'(ext_f);
        assign tick[g] = cnt_q >= div - 19'h0_0001;
        always_ff @(posedge clk) begin
            if (!rst_n || tick[g]) begin
                cnt_q <= 19'h0_0000;
            end else begin
                cnt_q <= cnt_q + 19'h0_0001;
            end
        end
    end

    // ********************************
    // Transmitter
    // ********************************
    logic tx_busy_q, tdr_full_q, idle_pend_q, tx_en_dly_q, brk_frame_q, brk_tail_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_left_q, tx_sub_q;
    logic [7:0] tdr_q;

    wire [3:0] frame_bits = word9_q ? `ASTX_BITS_9 : `ASTX_BITS_8;
    wire te_rise = tx_en_q & ~tx_en_dly_q;
    wire tx_bit_end = tx_busy_q & tick[0] & (tx_sub_q == `ASTX_SUB_LAST);
    wire tx_done = tx_bit_end & (tx_left_q == 4'h1);

    // Load priority: idle, break, break tail, buffer, direct write
    wire tx_free = ~tx_busy_q & tx_en_q;
    wire ld_idle = tx_free & idle_pend_q;
    wire ld_brk = tx_free & ~idle_pend_q & brk_q;
    wire ld_tail = tx_free & ~idle_pend_q & ~brk_q & brk_tail_q;
    wire ld_buf = tx_free & ~idle_pend_q & ~brk_q & ~brk_tail_q & tdr_full_q;
    wire ld_dir = tx_free & ~idle_pend_q & ~brk_q & ~brk_tail_q & ~tdr_full_q
                  & data_wr;
    wire tx_load = ld_idle | ld_brk | ld_tail | ld_buf | ld_dir;
    wire [10:0] ld_frame = (ld_idle | ld_tail) ? `ASTX_FRAME_ONES :
                           ld_brk ? `ASTX_FRAME_ZERO :
                           tx_frame(word9_q, {tx_ninth_q, ld_buf ? tdr_q : pw[7:0]});

    // Shift engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_busy_q <= 1'b0;
            tx_sh_q <= `ASTX_FRAME_ONES;
            tx_left_q <= 4'h0;
            tx_sub_q <= 4'h0;
            brk_frame_q <= 1'b0;
        end else if (tx_load) begin
            tx_busy_q <= 1'b1;
            tx_sh_q <= ld_frame;
            tx_left_q <= ld_tail ? 4'h1 : frame_bits;
            tx_sub_q <= 4'h0;
            brk_frame_q <= ld_brk;
        end else if (tx_busy_q & tick[0]) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_bit_end) begin
                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                tx_left_q <= tx_left_q - 4'h1;
                tx_busy_q <= ~tx_done;
            end
        end
    end

    // Buffer, idle request and break tail
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tdr_q <= `ASTX_RST_BYTE;
            tdr_full_q <= 1'b0;
            idle_pend_q <= 1'b0;
            tx_en_dly_q <= 1'b0;
            brk_tail_q <= 1'b0;
        end else begin
            tx_en_dly_q <= tx_en_q;
            if (data_wr & ~ld_dir) tdr_q <= pw[7:0];
            tdr_full_q <= (tdr_full_q & ~ld_buf & ~te_rise) | (data_wr & ~ld_dir);
            idle_pend_q <= (idle_pend_q & ~ld_idle) | te_rise;
            brk_tail_q <= (brk_tail_q & ~ld_tail) | (tx_done & brk_frame_q & ~brk_q);
        end
    end

    // Transmit flags, set wins over the software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_buffer_empty_flag_q <= 1'b1;
            tc_q <= 1'b1;
        end else begin
            tx_buffer_empty_flag_q <= (tx_buffer_empty_flag_q & ~wr_clr) | ld_buf | ld_dir | te_rise;
            tc_q <= (tc_q & ~wr_clr) | tx_done;
        end
    end

    // Pin stays driven until a frame started before disable ends
    assign tx_out = tx_busy_q ? tx_sh_q[0] : 1'b1;
    assign tx_oe = tx_en_q | tx_busy_q;

    // ********************************
    // Receiver
    // ********************************
    astx_rx_e rx_st_q;
    logic [3:0] rx_sub_q, rx_bit_q;
    logic [2:0] rx_hist_q, rx_vote_q;
    logic rx_edge_ok_q, rx_nz_q, nf_hold_q, idle_arm_q;
    logic [8:0] rx_sh_q;
    logic [7:0] idle_cnt_q;

    // Vote of samples 8, 9, 10
    wire rt = tick[1];
    wire v_maj = (rx_vote_q[0] & rx_vote_q[1]) | (rx_vote_q[0] & rx_vote_q[2])
                 | (rx_vote_q[1] & rx_vote_q[2]);
    wire v_noise = ~(&rx_vote_q) & (|rx_vote_q);
    wire rx_bit_end = rt & (rx_sub_q == `ASTX_SUB_LAST);
    wire [3:0] ndata = word9_q ? `ASTX_DATA_9 : `ASTX_DATA_8;
    wire rx_false = (rx_st_q == RX_START) & rx_bit_end & v_maj;
    wire rx_done = (rx_st_q == RX_DATA) & rx_bit_end & (rx_bit_q == ndata);
    wire rx_accept = rx_done & ~rx_full_q;
    wire rx_noise = rx_nz_q | v_noise | nf_hold_q;
    wire [8:0] rx_word = word9_q ? rx_sh_q : {1'b0, rx_sh_q[7:0]};
    wire rx_begin = (rx_st_q == RX_HUNT) & rt & ~serial_in_pin;
    wire mid_early = (rx_sub_q == `ASTX_SUB_S3) | (rx_sub_q == `ASTX_SUB_S5)
                     | (rx_sub_q == `ASTX_SUB_S7);
    wire in_vote = (rx_sub_q >= `ASTX_SUB_S8) & (rx_sub_q <= `ASTX_SUB_S10);
    wire idle_hit = (rx_st_q == RX_HUNT) & rt & serial_in_pin & idle_arm_q
                    & (idle_cnt_q == {frame_bits, 4'h0});

    // Frame sequencer
    always_ff @(posedge clk) begin
        if (!rst_n || !rx_en_q) begin
            rx_st_q <= RX_HUNT;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_nz_q <= 1'b0;
            rx_edge_ok_q <= 1'b0;
        end else if (rt) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            unique case (rx_st_q)
                RX_HUNT: begin
                    rx_sub_q <= 4'h1;
                    rx_nz_q <= 1'b0;
                    rx_edge_ok_q <= rx_hist_q == 3'b111;
                    if (!serial_in_pin) rx_st_q <= RX_START;
                end
                RX_START: begin
                    if (mid_early & serial_in_pin) rx_nz_q <= 1'b1;
                    if (rx_bit_end) begin
                        rx_st_q <= v_maj ? RX_HUNT : RX_DATA;
                        rx_bit_q <= 4'h0;
                        rx_nz_q <= rx_nz_q | ~rx_edge_ok_q | v_noise;
                    end
                end
                RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_bit_q <= rx_bit_q + 4'h1;
                        rx_nz_q <= rx_nz_q | v_noise;
                        if (rx_done) rx_st_q <= RX_HUNT;
                    end
                end
            endcase
        end
    end

    // Sample history, vote and data shifter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_hist_q <= 3'b000;
            rx_vote_q <= 3'b000;
            rx_sh_q <= `ASTX_RST_WORD;
        end else if (rt) begin
            rx_hist_q <= {rx_hist_q[1:0], serial_in_pin};
            if (in_vote) rx_vote_q <= {rx_vote_q[1:0], serial_in_pin};
            if ((rx_st_q == RX_DATA) & rx_bit_end & ~rx_done) begin
                rx_sh_q[rx_bit_q] <= v_maj;
            end
        end
    end

    // Idle-line detector: one full frame of ones after activity
    always_ff @(posedge clk) begin
        if (!rst_n || !rx_en_q || rx_begin) begin
            idle_cnt_q <= 8'h00;
            idle_arm_q <= rst_n & rx_en_q & rx_begin;
        end else if ((rx_st_q == RX_HUNT) & rt) begin
            idle_cnt_q <= idle_hit ? 8'h00 : idle_cnt_q + 8'h01;
            if (idle_hit) idle_arm_q <= 1'b0;
        end
    end

    // Receive buffer and flags, set wins over the software clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rbuf_q <= `ASTX_RST_WORD;
            {rx_full_q, idle_q, ovr_q, nf_q, fe_q, nf_hold_q} <= 6'h00;
        end else begin
            if (rx_accept) rbuf_q <= rx_word;
            rx_full_q <= (rx_full_q & ~rd_clr) | rx_done;
            ovr_q <= (ovr_q & ~rd_clr) | (rx_done & rx_full_q);
            nf_q <= (nf_q & ~rd_clr) | (rx_accept & rx_noise);
            fe_q <= (fe_q & ~rd_clr) | (rx_accept & ~v_maj);
            idle_q <= (idle_q & ~rd_clr) | idle_hit;
            nf_hold_q <= (nf_hold_q & ~rx_accept) | rx_false;
        end
    end

    // ********************************
    // Interrupt request
    // ********************************
    assign irq_req = ~global_irq_mask & ((tie_q & tx_buffer_empty_flag_q) | (tx_complete_irq_enable_q & tc_q)
                     | (rie_q & (rx_full_q | ovr_q)) | (idle_line_irq_enable_q & idle_q));

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_te_rise;
        tx_en_q & ~tx_en_dly_q & ~tx_busy_q & ~brk_q;
    endsequence
    sequence s_overrun;
        rx_done & rx_full_q & ~rd_clr;
    endsequence

    chk_tx_lsb_first: assert property (tx_bit_end & ~tx_done |=> tx_out == $past(tx_sh_q[1]))
        else $error("transmit bit order wrong");
    chk_tx_buffer_empty_flag_clear_seq: assert property ($fell(tx_buffer_empty_flag_q) |-> $past(wr_clr))
        else $error("buffer-empty flag cleared without sequence");
    chk_direct_load: assert property (ld_dir |=> tx_busy_q & tx_buffer_empty_flag_q & ~tx_out)
        else $error("direct write did not start frame");
    chk_tc_on_done: assert property (tx_done |=> tc_q ##0 ~tx_busy_q)
        else $error("complete flag missing after frame");
    chk_irq_tx_buffer_empty_flag: assert property (tx_buffer_empty_flag_q & tie_q & ~global_irq_mask |-> irq_req)
        else $error("buffer-empty interrupt missing");
    chk_idle_first: assert property (s_te_rise |-> ##[1:3] (tx_busy_q & tx_out))
        else $error("no idle frame after enable");
    chk_rx_full_set: assert property (rx_accept |=> rx_full_q & rbuf_q == $past(rx_word))
        else $error("receive buffer not loaded");
    chk_overrun_keep: assert property (s_overrun |=> ovr_q & $stable(rbuf_q))
        else $error("overrun handling wrong");
    chk_rxf_clear_seq: assert property ($fell(rx_full_q) |-> $past(rd_clr))
        else $error("receive flag cleared without sequence");
    chk_false_start: assert property (rx_false |=> rx_st_q == RX_HUNT & nf_hold_q
                                      & ~$rose(rx_full_q))
        else $error("false start not dropped");
    chk_stop_fe: assert property (rx_accept & ~v_maj |=> fe_q & rx_full_q)
        else $error("framing error not flagged");
endmodule
`default_nettype wire

// file: test/astx_peer.sv
// Purpose: Serial peer that talks to the core over its two pins
// Assumes: 8-bit frames, bit length fixed in clk cycles
// Notes: Transmit pin reads high through a pull-up when not driven
`timescale 1ns/100ps
`default_nettype none
module astx_peer #(
    parameter int BIT_CLKS = 32
) (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic tx_out,
    input wire logic tx_oe,
    output logic rx_line
);
    // ****************************************
    // Line level and frame capture
    // ****************************************
    wire logic line = tx_oe ? tx_out : 1'b1;
    logic [7:0] got[$];
    logic [7:0] sh;
    initial rx_line = 1'b1;
    // Mid-bit sampling after each falling edge, first bit is the LSB
    always begin
        @(negedge line);
        repeat (BIT_CLKS / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk);
            sh = {line, sh[7:1]};
        end
        repeat (BIT_CLKS) @(posedge clk);
        got.push_back(sh);
    end
    // One frame; a low stop bit models a break or framing fault
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            rx_line <= f[i];
            repeat (BIT_CLKS - 1) @(posedge clk);
        end
        @(posedge clk);
        rx_line <= 1'b1;
    endtask
    // Short low pulse; too short to pass the mid-bit vote of a start bit
    task automatic glitch(input int n);
        @(posedge clk);
        rx_line <= 1'b0;
        repeat (n) @(posedge clk);
        rx_line <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: test/astx_uart_tb_top.sv
// Purpose: Self-checking bench for the serial core
// Assumes: Both extended prescalers at 2, so 32 clocks per bit
// Notes: Registers reached only through the APB task
`timescale 1ns/100ps
`include "astx_consts.svh"
`default_nettype none
module astx_uart_tb_top;
    import astx_pkg::*;
    localparam int BITC = 32;
    logic clk;
    logic rst_n;
    astx_apb_req_s req;
    astx_apb_rsp_s rsp;
    logic rx_line;
    logic tx_out;
    logic tx_oe;
    logic irq_mask;
    logic irq_req;
    logic [31:0] rdata;
    logic rerr;
    int failures;
    int cmp_count;
    // ****************************************
    // Instances and clock
    // ****************************************
    astx_uart dut (
        .clk(clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .serial_in_pin(rx_line), .tx_out(tx_out), .tx_oe(tx_oe),
        .global_irq_mask(irq_mask), .irq_req(irq_req)
    );
    astx_peer #(.BIT_CLKS(BITC)) peer (
        .clk(clk), .tx_out(tx_out), .tx_oe(tx_oe), .rx_line(rx_line)
    );
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Setup, then access held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1) begin
            failures++;
            end_of_test();
        end
        rdata = rsp.prdata;
        rerr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        failures = 0;
        cmp_count = 0;
        req = '0;
        rst_n = 1'b0;
        irq_mask = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        // Reset flags and an unmapped address
        apb(0, `ASTX_OFS_STATUS, 0);
        chk(rdata, 32'h0000_0003);
        apb(0, 8'h1C, 0);
        chk({31'h0, rerr}, 32'h0000_0001);
        chk({30'h0, tx_oe, tx_out}, 32'h0000_0001);
        // Rates first, since they must not move while enabled
        apb(1, `ASTX_OFS_ETX, 32'h0000_0002);
        apb(1, `ASTX_OFS_ERX, 32'h0000_0002);
        apb(1, `ASTX_OFS_CTRL2, 32'h0000_000B);
        @(posedge clk);
        chk({31'h0, irq_req}, 32'h0000_0001);
        irq_mask <= 1'b1;
        @(posedge clk);
        chk({31'h0, irq_req}, 32'h0000_0000);
        irq_mask <= 1'b0;
        // Idle frame, then a direct load and a buffered word
        repeat (12 * BITC) @(posedge clk);
        apb(0, `ASTX_OFS_STATUS, 0);
        apb(1, `ASTX_OFS_DATA, 32'h0000_00A5);
        apb(1, `ASTX_OFS_DATA, 32'h0000_005A);
        for (int i = 0; i < 40 * BITC && peer.got.size() < 2; i++) @(posedge clk);
        if (peer.got.size() < 2) begin
            failures++;
            end_of_test();
        end
        chk({24'h0, peer.got[0]}, 32'h0000_00A5);
        chk({24'h0, peer.got[1]}, 32'h0000_005A);
        repeat (BITC) @(posedge clk);
        chk({31'h0, tx_out}, 32'h0000_0001);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk(rdata, 32'h0000_0003);
        // Reception and the two-step clear
        peer.send(8'h3C, 1'b1);
        repeat (BITC) @(posedge clk);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk({31'h0, rdata[2]}, 32'h0000_0001);
        apb(0, `ASTX_OFS_DATA, 0);
        chk(rdata, 32'h0000_003C);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk({31'h0, rdata[2]}, 32'h0000_0000);
        // Overrun; the first data read drops the pending clear
        apb(0, `ASTX_OFS_DATA, 0);
        peer.send(8'h11, 1'b1);
        peer.send(8'h22, 1'b1);
        repeat (BITC) @(posedge clk);
        apb(0, `ASTX_OFS_DATA, 0);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk({30'h0, rdata[4], rdata[2]}, 32'h0000_0003);
        apb(0, `ASTX_OFS_DATA, 0);
        chk(rdata, 32'h0000_0011);
        // Break seen as a framing fault
        peer.send(8'h00, 1'b0);
        repeat (BITC) @(posedge clk);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk({31'h0, rdata[6]}, 32'h0000_0001);
        apb(0, `ASTX_OFS_DATA, 0);
        chk(rdata, 32'h0000_0000);
        // A full frame of ones after the break raises the idle flag
        repeat (12 * BITC) @(posedge clk);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk({31'h0, rdata[3]}, 32'h0000_0001);
        // Nine-bit mode: glitch rejected, then the peer's stop is the ninth bit
        apb(1, `ASTX_OFS_CTRL1, 32'h0000_0001);
        peer.glitch(8);
        repeat (2 * BITC) @(posedge clk);
        peer.send(8'h3C, 1'b1);
        repeat (2 * BITC) @(posedge clk);
        apb(0, `ASTX_OFS_STATUS, 0);
        chk({30'h0, rdata[5], rdata[2]}, 32'h0000_0003);
        apb(0, `ASTX_OFS_CTRL1, 0);
        chk(rdata, 32'h0000_0005);
        apb(0, `ASTX_OFS_DATA, 0);
        chk(rdata, 32'h0000_003C);
        end_of_test();
    end
endmodule
`default_nettype wire
